// ### design/psfs_top.sv
// Purpose: fault supervision, alert and converter store of an inrush switch
// Assumes: comparators and converter samples arrive asynchronously
// Notes:   analog gate drive and serial protocol live outside this block
//
// Contract
// - high input over threshold: off, set flags
// - high input clear 100ms permits retry
// - low input under threshold: off, set flags
// - low input good 100ms restarts switch
// - low input low at supply-up logs fault
// - presence edge sets presence change flag
// - card removal: off, clear card present
// - insertion clears faults but presence change
// - card low 100ms copies request pin
// - sense at 2mV while off: short
// - output sense low drives pin, flag
// - power bad fault gated by gate drive
// - enabled faults pull alert low
// - alert response or address releases alert
// - no realert until new fault edge
// - zero write clears fault unless present
// - whole fault clear on off events
// - latch mode: fault flags hold switch off
// - retry mode: present flags hold switch off
// - converter cycles three channels, ten hertz
// - test mode halts converter, allows writes
// - two bits select pin function
// - writing one to fault turns off in latch mode
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module psfs_top
  import psfs_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC, // shorten for simulation
  parameter int CONV_CYCLES   = CONV_CYC    // cycles per channel step
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire psfs_cmp_t   cmp_in,          // raw comparator levels
  input  wire logic        card_presence_pin,
  input  wire logic        switch_request_pin,
  input  wire logic [7:0]  adc_sample,      // sample for current channel
  output psfs_chan_t       adc_chan,        // channel being measured
  input  wire logic        alert_response,  // pulse: host answered alert
  input  wire logic        addressed,       // pulse: host addressed us
  output logic             switch_enable,   // pass switch may be on
  output logic             alert_n_out,
  output logic             alert_n_oe,
  input  wire logic        gp_pin_in,
  output logic             gp_pin_out,
  output logic             gp_pin_oe
);

  // two-flop synchronisers for comparators, pins and converter samples
  psfs_cmp_t  cmp_m_q, cmp_q;
  logic [2:0] pin_m_q, pin_q;
  logic [7:0] smp_m_q, smp_q;
  always_ff @(posedge ref_clk) begin
    cmp_m_q <= cmp_in;
    cmp_q   <= cmp_m_q;
    pin_m_q <= {gp_pin_in, switch_request_pin, card_presence_pin};
    pin_q   <= pin_m_q;
    smp_m_q <= adc_sample;
    smp_q   <= smp_m_q;
  end

  wire card_out = pin_q[0]; // high means card removed
  wire req_pin  = pin_q[1];
  wire gp_in    = pin_q[2];

  logic [7:0] ctrl_q;     // control register
  logic [5:0] alert_en_q; // alert enable mask
  logic [5:0] fault_q;    // sticky fault flags
  logic [5:0] fault_d;
  logic [7:0] res_q [3];  // converter results
  logic       card_q, req_q, sw_on_q, sup_q, gp_out_q;
  logic       short_q;    // short present
  logic       init_q;     // first cycle after reset, catch levels
  logic [5:0] alerted_q;  // faults already alerted and released
  logic       alert_q;    // alert line pulled
  logic [31:0] hi_cnt_q, lo_cnt_q, card_cnt_q, conv_cnt_q;
  logic       hi_ok_q, lo_ok_q, card_ok_q;
  psfs_chan_t chan_q;
  logic       apb_hit_q;  // answer pulse

  // apb decode: one wait state, pready on second access cycle
  wire acc      = psel & penable;
  wire acc_done = acc & apb_hit_q;
  wire wr       = acc_done & pwrite;
  wire known    = paddr inside {CTRL_OFS, ALERT_OFS, STATUS_OFS,
                                FAULT_OFS, VOUT_OFS, AUX_OFS, SENSE_OFS};
  wire wr_ctrl  = wr & (paddr == CTRL_OFS);
  wire wr_alert = wr & (paddr == ALERT_OFS);
  wire wr_fault = wr & (paddr == FAULT_OFS);
  wire test     = ctrl_q[CTRL_TEST];
  assign pready  = acc & apb_hit_q;
  assign pslverr = pready & ~known; // unmapped address errors

  // present flags
  wire hi_pres = cmp_q.hi_over | ~hi_ok_q;
  wire lo_pres = cmp_q.lo_under | ~lo_ok_q;
  wire oc_pres = cmp_q.oc_trip | (fault_q[FL_OC] & ~cmp_q.oc_clear);
  wire [5:0] status = {short_q, ~card_out, cmp_q.fb_low, oc_pres,
                       lo_pres, hi_pres};

  // off events that wipe the whole fault register
  wire req_fall  = req_q & ~req_pin;
  wire ctl_fall  = sw_on_q & ~ctrl_q[CTRL_SW_ON];
  wire wipe      = req_fall | ctl_fall | cmp_q.lo_reset | ~cmp_q.supply_ok;
  wire card_edge = card_q ^ card_out;
  wire insert    = card_q & ~card_out;

  // event sets for each fault flag
  wire [5:0] fault_set = {short_q, card_edge,
                          cmp_q.fb_low & cmp_q.gate_high,
                          cmp_q.oc_trip, cmp_q.lo_under, cmp_q.hi_over};

  // fault next state: sets win over every clear
  always_comb begin
    fault_d = fault_q;
    if (wr_fault) begin
      fault_d = pwdata[5:0] | (fault_q & status);
    end
    if (insert) begin
      fault_d = fault_d & ~NON_PRES;
    end
    if (wipe) begin
      fault_d = 6'h00;
    end
    if (init_q && cmp_q.lo_under) begin
      fault_d[FL_LO] = 1'b1;
    end
    fault_d = fault_d | fault_set;
  end

  // switch permission
  wire [2:0] ar_bits = ctrl_q[CTRL_OC_AR:CTRL_HI_AR];
  wire [2:0] hold_f  = fault_q[2:0] & ~ar_bits;
  wire [2:0] hold_p  = status[2:0] & ar_bits;
  wire [2:0] hold_lp = status[2:0] & ~ar_bits;
  assign switch_enable = ctrl_q[CTRL_SW_ON] & ~card_out & card_ok_q
                         & ~|hold_f & ~|hold_p & ~|hold_lp;

  // settle timers: hold time of each condition
  always_ff @(posedge ref_clk) begin
    if (srst || cmp_q.hi_over) begin
      hi_cnt_q <= 32'h0;
      hi_ok_q  <= ~cmp_q.hi_over & ~srst;
    end else if (!hi_ok_q) begin
      hi_cnt_q <= hi_cnt_q + 32'h1;
      hi_ok_q  <= (hi_cnt_q == 32'(SETTLE_CYCLES - 1));
    end
  end

  // low input settle timer
  always_ff @(posedge ref_clk) begin
    if (srst || cmp_q.lo_under) begin
      lo_cnt_q <= 32'h0;
      lo_ok_q  <= 1'b0;
    end else if (!lo_ok_q) begin
      lo_cnt_q <= lo_cnt_q + 32'h1;
      lo_ok_q  <= (lo_cnt_q == 32'(SETTLE_CYCLES - 1));
    end
  end

  // card presence settle timer, one pulse when it matures
  wire card_mature = ~card_out & ~card_ok_q
                     & (card_cnt_q == 32'(SETTLE_CYCLES - 1));
  always_ff @(posedge ref_clk) begin
    if (srst || card_out) begin
      card_cnt_q <= 32'h0;
      card_ok_q  <= 1'b0;
    end else if (!card_ok_q) begin
      card_cnt_q <= card_cnt_q + 32'h1;
      card_ok_q  <= card_mature;
    end
  end

  // control register: software write, request pin copy
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RST;
    end else if (card_mature) begin
      ctrl_q[CTRL_SW_ON] <= req_pin;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end else if (!req_q && req_pin) begin
      ctrl_q[CTRL_SW_ON] <= 1'b1; // request rising turns on
    end else if (req_fall) begin
      ctrl_q[CTRL_SW_ON] <= 1'b0;
    end
  end

  // plain state registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_q    <= 6'h00;
      alert_en_q <= ALERT_RST;
      card_q     <= 1'b1;
      req_q      <= req_pin; // track pin so release brings no false edge
      sw_on_q    <= 1'b0;
      init_q     <= 1'b1;
      apb_hit_q  <= 1'b0;
      gp_out_q   <= 1'b0;
    end else begin
      fault_q    <= fault_d;
      alert_en_q <= wr_alert ? pwdata[5:0] : alert_en_q;
      card_q     <= card_out;
      req_q      <= req_pin;
      sw_on_q    <= ctrl_q[CTRL_SW_ON];
      init_q     <= 1'b0;
      apb_hit_q  <= acc & ~apb_hit_q;
      gp_out_q   <= wr_ctrl ? pwdata[8] : gp_out_q;
    end
  end

  // alert: newly set enabled fault asserts, release remembers it
  wire [5:0] armed   = fault_q & alert_en_q & ~alerted_q;
  wire       release_a = alert_q & (alert_response | addressed);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alert_q   <= 1'b0;
      alerted_q <= 6'h00;
    end else begin
      alert_q   <= release_a ? 1'b0 : |armed;
      alerted_q <= (alerted_q & fault_q)
                   | (release_a ? (fault_q & alert_en_q) : 6'h00);
    end
  end
  assign alert_n_out = 1'b0;
  assign alert_n_oe  = alert_q;

  // converter: step channel, store sample, flag short when off
  wire conv_step = (conv_cnt_q == 32'(CONV_CYCLES - 1));
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      conv_cnt_q <= 32'h0;
      chan_q     <= CH_VOUT;
      short_q    <= 1'b0;
    end else if (!test) begin
      conv_cnt_q <= conv_step ? 32'h0 : conv_cnt_q + 32'h1;
      if (conv_step) begin
        unique case (chan_q)
          CH_VOUT:  chan_q <= CH_AUX;
          CH_AUX:   chan_q <= CH_SENSE;
          default:  chan_q <= CH_VOUT;
        endcase
        if (chan_q == CH_SENSE) begin
          short_q <= ~switch_enable & (smp_q >= SHORT_CODE);
        end
      end
    end
  end
  assign adc_chan = chan_q;

  // result store: converter or test-mode writes
  for (genvar i = 0; i < 3; i++) begin : g_res
    wire wr_res = wr & test & (paddr == VOUT_OFS + 8'(4 * i));
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        res_q[i] <= 8'h00;
      end else if (wr_res) begin
        res_q[i] <= pwdata[7:0];
      end else if (!test && conv_step && chan_q == psfs_chan_t'(i)) begin
        res_q[i] <= smp_q;
      end
    end
  end

  // read mux, registered on the wait cycle before the answer
  logic [31:0] rd_d;
  always_comb begin
    unique case (paddr)
      CTRL_OFS:   rd_d = {23'h0, gp_out_q, ctrl_q};
      ALERT_OFS:  rd_d = {26'h0, alert_en_q};
      STATUS_OFS: rd_d = {25'h0, gp_in, 6'(status)};
      FAULT_OFS:  rd_d = {26'h0, fault_q};
      VOUT_OFS:   rd_d = {24'h0, res_q[0]};
      AUX_OFS:    rd_d = {24'h0, res_q[1]};
      SENSE_OFS:  rd_d = {24'h0, res_q[2]};
      default:    rd_d = 32'h0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0;
    end else if (acc && !apb_hit_q) begin
      prdata <= rd_d;
    end
  end

  // general-purpose pin function
  wire [1:0] fsel = ctrl_q[CTRL_FSEL_H:CTRL_FSEL_L];
  assign gp_pin_out = (fsel == PF_GP_OUT) ? gp_out_q : 1'b0;
  assign gp_pin_oe  = (fsel == PF_HIZ_GOOD)  ? cmp_q.fb_low :
                      (fsel == PF_PULL_GOOD) ? ~cmp_q.fb_low :
                      (fsel == PF_GP_OUT);

  // checks
  hi_off_a: assert property (@(posedge ref_clk) disable iff (srst)
    cmp_q.hi_over |-> !switch_enable && fault_d[FL_HI])
    else $error("switch on during high input fault");
  lo_off_a: assert property (@(posedge ref_clk) disable iff (srst)
    cmp_q.lo_under |=> fault_q[FL_LO])
    else $error("low input fault not logged");
  card_rm_a: assert property (@(posedge ref_clk) disable iff (srst)
    card_out |-> !switch_enable && !status[FL_CARD])
    else $error("switch on with card removed");
  edge_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
    card_edge |=> fault_q[FL_CARD])
    else $error("presence change not flagged");
  wipe_all_a: assert property (@(posedge ref_clk) disable iff (srst)
    wipe && !(|fault_set) |=> fault_q == 6'h00)
    else $error("fault register not wiped");
  no_alert_a: assert property (@(posedge ref_clk) disable iff (srst)
    !(|(fault_q & alert_en_q)) |=> !alert_q)
    else $error("alert without enabled fault");
  rel_alert_a: assert property (@(posedge ref_clk) disable iff (srst)
    release_a |=> !alert_q)
    else $error("alert not released");
  test_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    test && !wr |=> $stable(res_q[0]) && $stable(res_q[2]))
    else $error("result changed in test mode");
  pbad_a: assert property (@(posedge ref_clk) disable iff (srst)
    cmp_q.fb_low && cmp_q.gate_high |=> fault_q[FL_PBAD])
    else $error("power bad fault missed");
  apb_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
    acc && !pready |=> pready || !acc)
    else $error("apb answer late");
  c_alert: cover property (@(posedge ref_clk) disable iff (srst)
    alert_q ##1 release_a);
  c_insert: cover property (@(posedge ref_clk) disable iff (srst)
    card_mature);
  c_short: cover property (@(posedge ref_clk) disable iff (srst)
    $rose(short_q));

endmodule // psfs_top
`default_nettype wire

// ### common/psfs_pkg.sv
// Purpose: shared constants and types for the power switch fault supervisor
// Assumes: 10 MHz ref_clk, 32-bit APB register access
// Notes:   byte offsets are word aligned
package psfs_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00; // control bits
  localparam logic [7:0] ALERT_OFS  = 8'h04; // alert enable mask
  localparam logic [7:0] STATUS_OFS = 8'h08; // present flags, read only
  localparam logic [7:0] FAULT_OFS  = 8'h0c; // sticky fault flags
  localparam logic [7:0] VOUT_OFS   = 8'h10; // output voltage result
  localparam logic [7:0] AUX_OFS    = 8'h14; // auxiliary input result
  localparam logic [7:0] SENSE_OFS  = 8'h18; // sense voltage result

  // control field positions
  localparam int CTRL_HI_AR  = 0; // high input autoretry
  localparam int CTRL_LO_AR  = 1; // low input autoretry
  localparam int CTRL_OC_AR  = 2; // overcurrent autoretry
  localparam int CTRL_SW_ON  = 3; // switch-on control
  localparam int CTRL_TEST   = 5; // converter test mode
  localparam int CTRL_FSEL_L = 6; // pin function select low
  localparam int CTRL_FSEL_H = 7; // pin function select high

  // flag bit positions shared by status, fault and alert registers
  localparam int FL_HI    = 0;
  localparam int FL_LO    = 1;
  localparam int FL_OC    = 2;
  localparam int FL_PBAD  = 3;
  localparam int FL_CARD  = 4; // card present / presence change
  localparam int FL_SHORT = 5;

  localparam logic [7:0] CTRL_RST  = 8'h07; // autoretry on, pin hi-z on good
  localparam logic [5:0] ALERT_RST = 6'h00; // no alerts after reset
  localparam logic [5:0] NON_PRES  = 6'h2f; // every flag but presence change

  // timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int SETTLE_MS    = 100;
  localparam int SETTLE_CYC   = CLK_HZ / 1000 * SETTLE_MS;
  localparam int RESULT_HZ    = 10; // refresh rate of each result
  localparam int CONV_CYC     = CLK_HZ / (RESULT_HZ * 3);
  localparam logic [7:0] SHORT_CODE = 8'h07; // 2 mV at 300 uV per step

  typedef enum logic [1:0] {
    PF_HIZ_GOOD  = 2'b00, // release when power good (default)
    PF_PULL_GOOD = 2'b01, // pull down when power good
    PF_GP_OUT    = 2'b10, // general purpose output
    PF_GP_IN     = 2'b11  // general purpose input
  } psfs_pinfn_t;

  typedef enum logic [1:0] {
    CH_VOUT  = 2'b00,
    CH_AUX   = 2'b01,
    CH_SENSE = 2'b10
  } psfs_chan_t;

  // comparator inputs carried together
  typedef struct packed {
    logic hi_over;   // high input above threshold
    logic lo_under;  // low input below trip threshold
    logic lo_reset;  // low input below reset level
    logic oc_trip;   // overcurrent timer expired
    logic oc_clear;  // timer discharged
    logic fb_low;    // output sense below threshold
    logic gate_high; // gate-to-source drive high
    logic supply_ok; // internal supply above lockout
  } psfs_cmp_t;

endpackage : psfs_pkg

// ### dv/psfs_host_model.sv
// Purpose: host side that services the alert line of the supervisor
// Assumes: alert wire has a pull-up; answers are one-cycle pulses
// Notes:   answers once per alert, by response read or by addressing
`timescale 1ns/10ps
`default_nettype none
module psfs_host_model (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       alert_line,     // wired level, high when idle
  input  wire logic       use_address,    // answer by direct addressing
  input  wire logic [7:0] svc_delay,      // cycles before the answer
  output logic            alert_response,
  output logic            addressed
);
  logic [7:0] wait_q; // cycles the alert has been seen low
  logic       answer; // this cycle the host answers the alert
  // a slow host leaves the alert standing; only one answer per alert
  // so a device that never releases stays visibly low
  always_ff @(posedge ref_clk) begin
    if (srst || alert_line) begin
      wait_q <= 8'h00;
    end else if (wait_q != 8'hff) begin
      wait_q <= wait_q + 8'h01;
    end
  end
  assign answer = !srst && !alert_line && (wait_q == svc_delay);
  // each answer line is written once per edge
  always_ff @(posedge ref_clk) begin
    alert_response <= answer && !use_address;
    addressed      <= answer && use_address;
  end
endmodule // psfs_host_model
`default_nettype wire

// ### dv/tb.sv
// Purpose: self-checking bench for the power switch fault supervisor
// Assumes: shortened settle and conversion counts
// Notes:   registers reached over APB; host model answers alerts
`timescale 1ns/10ps
`default_nettype none
module tb;
  import psfs_pkg::*;
  localparam int ST = 20; // shortened settle count
  localparam int CV = 8;  // shortened channel step
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, adc_sample, sense_val, svc_delay;
  logic [31:0] pwdata, prdata, rdata, bm;
  logic        switch_enable, alert_n_out, alert_n_oe, eoe, err;
  logic        card_presence_pin, switch_request_pin, gp_pin_in;
  logic        gp_pin_out, gp_pin_oe, alert_response, addressed;
  logic        use_address;
  psfs_cmp_t   cmp_in;      // comparator levels
  psfs_chan_t  adc_chan;    // channel under conversion
  int          num_errors, checked;
  int          cycles = 0;  // timeout counter
  wire logic   alert_line = alert_n_oe ? alert_n_out : 1'b1; // pull-up

  psfs_top #(.SETTLE_CYCLES(ST), .CONV_CYCLES(CV)) u_psfs_top (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cmp_in(cmp_in),
    .card_presence_pin(card_presence_pin),
    .switch_request_pin(switch_request_pin), .adc_sample(adc_sample),
    .adc_chan(adc_chan), .alert_response(alert_response),
    .addressed(addressed), .switch_enable(switch_enable),
    .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe));

  psfs_host_model u_psfs_host_model (
    .ref_clk(ref_clk), .srst(srst), .alert_line(alert_line),
    .use_address(use_address), .svc_delay(svc_delay),
    .alert_response(alert_response), .addressed(addressed));

  // clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // converter front end: sense channel is set by the test
  always @(posedge ref_clk) begin
    adc_sample <= (adc_chan == CH_SENSE) ? sense_val
                                          : 8'h30 + {6'h00, adc_chan};
  end

  // hang guard, well beyond the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one apb transfer; waits for pready, no latency assumed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the hang guard ends a wait that never answers
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // masked register read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask

  // short excursion of the high input
  task automatic trip_hi();
    cmp_in.hi_over <= 1'b1;
    cyc(6);
    cmp_in.hi_over <= 1'b0;
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmp_in = '0;
    cmp_in.supply_ok = 1'b1;
    card_presence_pin = 1'b1;
    switch_request_pin = 1'b1;
    gp_pin_in = 1'b1;
    adc_sample = 8'h00;
    sense_val = 8'h06;
    svc_delay = 8'd15;
    use_address = 1'b0;
    num_errors = 0;
    checked = 0;
    cyc(8);
    srst <= 1'b0;
    rdc(CTRL_OFS, 32'hff, {24'h0, CTRL_RST});
    rdc(ALERT_OFS, 32'hffffffff, {26'h0, ALERT_RST});
    rdc(8'h1c, 32'hffffffff, 32'h0);
    chk(err, 1'b1);
    // insertion, then settle copies the request pin
    card_presence_pin <= 1'b0;
    cyc(ST + 8);
    chk(switch_enable, 1'b1);
    rdc(STATUS_OFS, 32'h3f, 32'h10);
    rdc(FAULT_OFS, 32'h3f, 32'h10);
    // high then low input trip, alerts masked
    for (int i = 0; i < 2; i++) begin
      bm = 32'h1 << i;
      cmp_in <= psfs_cmp_t'(cmp_in | (8'h80 >> i));
      cyc(6);
      chk(switch_enable, 1'b0);
      chk(alert_line, 1'b1);
      rdc(STATUS_OFS, 32'h3f, 32'h10 | bm);
      rdc(FAULT_OFS, 32'h3f, 32'h10 | bm);
      apb(1'b1, FAULT_OFS, 32'h0);
      rdc(FAULT_OFS, 32'h3f, 32'h10 | bm);
      cmp_in <= psfs_cmp_t'(cmp_in & ~(8'h80 >> i));
      cyc(6);
      chk(switch_enable, 1'b0);
      cyc(ST);
      chk(switch_enable, 1'b1);
      rdc(FAULT_OFS, 32'h3f, 32'h10 | bm);
      apb(1'b1, FAULT_OFS, 32'h0);
      rdc(FAULT_OFS, 32'h3f, 32'h10);
    end
    // alert serviced by response read, then by addressing
    apb(1'b1, ALERT_OFS, 32'h1);
    rdc(ALERT_OFS, 32'hffffffff, 32'h1);
    for (int k = 0; k < 2; k++) begin
      use_address <= k[0];
      trip_hi();
      chk(alert_line, 1'b0);
      cyc(20);
      chk(alert_line, 1'b1);
      trip_hi();
      cyc(10);
      chk(alert_line, 1'b1);
      cyc(ST);
      apb(1'b1, FAULT_OFS, 32'h0);
    end
    // latch mode on the high input
    apb(1'b1, ALERT_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0e);
    trip_hi();
    cyc(ST + 6);
    chk(switch_enable, 1'b0);
    apb(1'b1, FAULT_OFS, 32'h0);
    cyc(2);
    chk(switch_enable, 1'b1);
    apb(1'b1, FAULT_OFS, 32'h1);
    cyc(2);
    chk(switch_enable, 1'b0);
    apb(1'b1, FAULT_OFS, 32'h0);
    // every pin function against good and bad output
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CTRL_OFS, 32'h10f | (m << 6));
      for (int b = 0; b < 2; b++) begin
        cmp_in.fb_low <= b[0];
        cyc(5);
        eoe = (m == 0) ? b[0] : (m == 1) ? !b[0] : (m == 2);
        chk({gp_pin_oe, gp_pin_out & eoe}, {eoe, eoe & (m == 2)});
        rdc(STATUS_OFS, 32'h08, {b[0], 3'h0});
      end
      if (m == 3) begin
        rdc(STATUS_OFS, 32'h40, 32'h40);
        gp_pin_in <= 1'b0;
        cyc(3);
        rdc(STATUS_OFS, 32'h40, 32'h0);
      end
    end
    rdc(FAULT_OFS, 32'h08, 32'h0);
    cmp_in.gate_high <= 1'b1;
    cyc(5);
    rdc(FAULT_OFS, 32'h08, 32'h08);
    cmp_in.fb_low <= 1'b0;
    cmp_in.gate_high <= 1'b0;
    cyc(4);
    apb(1'b1, FAULT_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0f);
    // removal and reinsertion
    card_presence_pin <= 1'b1;
    cyc(5);
    chk(switch_enable, 1'b0);
    rdc(STATUS_OFS, 32'h10, 32'h0);
    apb(1'b1, FAULT_OFS, 32'h0);
    trip_hi();
    cyc(4);
    rdc(FAULT_OFS, 32'h3f, 32'h01);
    card_presence_pin <= 1'b0;
    cyc(5);
    rdc(FAULT_OFS, 32'h3f, 32'h10);
    rdc(STATUS_OFS, 32'h10, 32'h10);
    cyc(ST + 4);
    chk(switch_enable, 1'b1);
    cmp_in.lo_reset <= 1'b1;
    cyc(4);
    cmp_in.lo_reset <= 1'b0;
    rdc(FAULT_OFS, 32'h3f, 32'h0);
    // converter results, request pin turn-off, short detection
    cyc(6 * CV + 6);
    rdc(VOUT_OFS, 32'hff, 32'h30);
    rdc(AUX_OFS, 32'hff, 32'h31);
    switch_request_pin <= 1'b0;
    cyc(5);
    rdc(FAULT_OFS, 32'h3f, 32'h0);
    cyc(6 * CV);
    rdc(SENSE_OFS, 32'hff, 32'h06);
    rdc(STATUS_OFS, 32'h20, 32'h0);
    sense_val <= SHORT_CODE;
    cyc(6 * CV);
    rdc(STATUS_OFS, 32'h20, 32'h20);
    rdc(FAULT_OFS, 32'h20, 32'h20);
    apb(1'b1, CTRL_OFS, 32'h27);
    apb(1'b1, VOUT_OFS, 32'h5a);
    cyc(6 * CV);
    rdc(VOUT_OFS, 32'hff, 32'h5a);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
